// ---- pifr_regs.vh ----
`ifndef PIFR_REGS_VH
`define PIFR_REGS_VH

// register indices; byte address is four times the index
`define PIFR_IDX_W          12
`define PIFR_IDX_SER_CHAN   12'hE37
`define PIFR_IDX_TMR_MATCH  12'hE38
`define PIFR_IDX_TMR_GATE   12'hE39
`define PIFR_IDX_CAPCOMP    12'hE3A
`define PIFR_IDX_SSP_DONE   12'hE40
`define PIFR_IDX_RX3        12'hE41
`define PIFR_IDX_RX4        12'hE42
`define PIFR_IDX_RX5        12'hE43
`define PIFR_IDX_TX3        12'hE44
`define PIFR_IDX_TX4        12'hE45
`define PIFR_IDX_TX5        12'hE46

// decoded register select codes
`define PIFR_SEL_W          4
`define PIFR_SEL_NONE       4'h0
`define PIFR_SEL_SER_CHAN   4'h1
`define PIFR_SEL_TMR_MATCH  4'h2
`define PIFR_SEL_TMR_GATE   4'h3
`define PIFR_SEL_CAPCOMP    4'h4
`define PIFR_SEL_SSP_DONE   4'h5
`define PIFR_SEL_RX         4'h6
`define PIFR_SEL_TX         4'h7

// field widths and positions
`define PIFR_NUM_SSP        2
`define PIFR_SSP0_BIT       0
`define PIFR_SSP1_BIT       2
`define PIFR_NUM_UART       3
`define PIFR_UART_DW        8
`define PIFR_NUM_TMR        8
`define PIFR_NUM_GATE       4
`define PIFR_NUM_CCP        5
`define PIFR_CCP_MODE_W     2

// capture/compare module modes
`define PIFR_CCP_OFF        2'h0
`define PIFR_CCP_CAPTURE    2'h1
`define PIFR_CCP_COMPARE    2'h2
`define PIFR_CCP_PWM        2'h3

// reset values
`define PIFR_RST_FLAG       1'b0
`define PIFR_RST_BYTE       8'h00
`define PIFR_RST_WORD       32'h0000_0000

`endif

// ---- pifr_flag_bank.v ----
`timescale 1ns/1ns
`default_nettype none
`include "pifr_regs.vh"

module pifr_flag_bank #(
  parameter W = 8
) (
  // clock and reset
  input  wire         ref_clk,
  input  wire         nrst,
  // hardware events, one per flag
  input  wire [W-1:0] set,
  // software write
  input  wire         wr_en,
  input  wire [W-1:0] wr_data,
  // flag state
  output reg  [W-1:0] flags
);

  reg [W-1:0] next_flags;

  // a set in the cycle of a write still lands, so no event is lost
  always @* begin
    next_flags = (wr_en ? wr_data : flags) | set;
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flags <= {W{`PIFR_RST_FLAG}};
    end else begin
      flags <= next_flags;
    end
  end

endmodule // pifr_flag_bank

`default_nettype wire

// ---- pifr_flag_regs.v ----
`timescale 1ns/1ns
`default_nettype none
`include "pifr_regs.vh"

// Notes on behaviour
// - Each synchronous serial port done flag (bits 0 and 2) sets when its port finishes a transfer and holds until software clears it.
// - Each async channel receive flag (bits 5, 3, 1) is high while its receive buffer holds data and drops when software reads that buffer.
// - Each async channel transmit flag (bits 4, 2, 0) is high while its transmit buffer is empty and drops when software writes that buffer.
// - The serial channel flag register at 0xE37 is read-only, follows buffer state only, and its two top bits read zero.
// - Timer period-match flags sit timer eight at bit 7 down to timer one at bit 0, set on count equal to period, and hold until cleared.
// - Gate flags for timers seven, five, three, one sit at bits 3 to 0, hold until cleared, and bits 7 to 4 read zero.
// - Five capture/compare flags are readable and writable at bits 4 to 0 of 0xE3A, with bits 7 to 5 reading zero.
// - All timer-match, timer-gate and capture/compare flags reset to zero and are readable and writable by software.
// - A capture/compare flag sets on a capture in capture mode or on a match in compare mode, never in PWM mode, and software clears it.
// - Flags set on their events regardless of any interrupt enable, so software can poll them.

module pifr_flag_regs #(
  parameter TMR_W  = 8,
  parameter ADDR_W = 14
) (
  // clock and reset
  input  wire                          ref_clk,
  input  wire                          nrst,
  // avalon-mm register slave, byte addressed
  input  wire [ADDR_W-1:0]             avs_address,
  input  wire                          avs_read,
  input  wire                          avs_write,
  input  wire [3:0]                    avs_byteenable,
  input  wire [31:0]                   avs_writedata,
  output reg  [31:0]                   avs_readdata,
  output wire                          avs_waitrequest,
  // synchronous serial port completion pulses
  input  wire [`PIFR_NUM_SSP-1:0]      ssp_done,
  // async channels, index 0 is channel three
  input  wire [`PIFR_NUM_UART-1:0]     uart_rx_load,
  input  wire [`PIFR_NUM_UART*8-1:0]   uart_rx_data,
  input  wire [`PIFR_NUM_UART-1:0]     uart_tx_take,
  output reg  [`PIFR_NUM_UART*8-1:0]   uart_tx_data,
  output reg  [`PIFR_NUM_UART-1:0]     uart_tx_full,
  // timers, index 0 is timer one
  input  wire [`PIFR_NUM_TMR*TMR_W-1:0] tmr_count,
  input  wire [`PIFR_NUM_TMR*TMR_W-1:0] tmr_period,
  input  wire [`PIFR_NUM_GATE-1:0]     tmr_gate_event,
  // capture/compare modules
  input  wire [`PIFR_NUM_CCP*2-1:0]    ccp_mode,
  input  wire [`PIFR_NUM_CCP-1:0]      ccp_capture,
  input  wire [`PIFR_NUM_CCP-1:0]      ccp_match,
  // flag state toward the core interrupt logic
  output wire [7:0]                    serial_port_flags,
  output wire [7:0]                    serial_channel_flags,
  output wire [7:0]                    timer_match_flags,
  output wire [7:0]                    timer_gate_flags,
  output wire [7:0]                    capture_compare_flags
);

  localparam NU = `PIFR_NUM_UART;
  localparam UW = `PIFR_UART_DW;

  // bus handshake: one wait state, answer on the second edge
  reg                    ack;
  reg  [`PIFR_SEL_W-1:0] sel;
  reg  [1:0]             chan;
  wire [`PIFR_IDX_W-1:0] idx;
  wire                   req;
  wire                   wr_fire;
  wire                   rd_fire;

  assign idx = avs_address[`PIFR_IDX_W+1:2];
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack;
  assign wr_fire = avs_write & ack & avs_byteenable[0];
  assign rd_fire = avs_read & ack;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack <= `PIFR_RST_FLAG;
    end else begin
      ack <= req & ~ack;
    end
  end

  // address decode
  always @* begin
    sel  = `PIFR_SEL_NONE;
    chan = 2'h0;
    if (idx == `PIFR_IDX_SER_CHAN) begin
      sel = `PIFR_SEL_SER_CHAN;
    end else if (idx == `PIFR_IDX_TMR_MATCH) begin
      sel = `PIFR_SEL_TMR_MATCH;
    end else if (idx == `PIFR_IDX_TMR_GATE) begin
      sel = `PIFR_SEL_TMR_GATE;
    end else if (idx == `PIFR_IDX_CAPCOMP) begin
      sel = `PIFR_SEL_CAPCOMP;
    end else if (idx == `PIFR_IDX_SSP_DONE) begin
      sel = `PIFR_SEL_SSP_DONE;
    end else if (idx == `PIFR_IDX_RX3) begin
      sel = `PIFR_SEL_RX;
    end else if (idx == `PIFR_IDX_RX4) begin
      sel  = `PIFR_SEL_RX;
      chan = 2'h1;
    end else if (idx == `PIFR_IDX_RX5) begin
      sel  = `PIFR_SEL_RX;
      chan = 2'h2;
    end else if (idx == `PIFR_IDX_TX3) begin
      sel = `PIFR_SEL_TX;
    end else if (idx == `PIFR_IDX_TX4) begin
      sel  = `PIFR_SEL_TX;
      chan = 2'h1;
    end else if (idx == `PIFR_IDX_TX5) begin
      sel  = `PIFR_SEL_TX;
      chan = 2'h2;
    end
    // address bits above the index must be zero to hit anything
    // a shift, since a part-select would run backwards with no bits above
    if ((avs_address >> (`PIFR_IDX_W + 2)) != {ADDR_W{1'b0}}) begin
      sel = `PIFR_SEL_NONE;
    end
  end

  // synchronous serial port done flags at bits 2 and 0
  wire [`PIFR_NUM_SSP-1:0] ssp_q;
  wire [`PIFR_NUM_SSP-1:0] ssp_wr;

  assign ssp_wr = {avs_writedata[`PIFR_SSP1_BIT],
                   avs_writedata[`PIFR_SSP0_BIT]};

  pifr_flag_bank #(
    .W (`PIFR_NUM_SSP)
  ) u_ssp (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .set     (ssp_done),
    .wr_en   (wr_fire & (sel == `PIFR_SEL_SSP_DONE)),
    .wr_data (ssp_wr),
    .flags   (ssp_q)
  );

  assign serial_port_flags = {5'h00, ssp_q[1], 1'b0, ssp_q[0]};

  // async channel buffers and their level flags
  reg  [NU-1:0]    rx_full;
  reg  [NU-1:0]    next_rx_full;
  reg  [NU*UW-1:0] rx_buf;
  reg  [NU-1:0]    tx_empty;
  reg  [NU-1:0]    next_tx_full;
  reg  [NU*UW-1:0] next_tx_data;
  reg  [NU*UW-1:0] next_rx_buf;
  integer          i;

  always @* begin
    next_rx_full = rx_full;
    next_rx_buf  = rx_buf;
    next_tx_full = uart_tx_full;
    next_tx_data = uart_tx_data;
    for (i = 0; i < NU; i = i + 1) begin
      // reading the buffer empties it; a byte landing then refills it
      if (rd_fire && sel == `PIFR_SEL_RX && chan == i) begin
        next_rx_full[i] = 1'b0;
      end
      if (uart_rx_load[i]) begin
        next_rx_full[i] = 1'b1;
        next_rx_buf[i*UW +: UW] = uart_rx_data[i*UW +: UW];
      end
      // the shifter takes the byte, then a write refills the buffer
      if (uart_tx_take[i]) begin
        next_tx_full[i] = 1'b0;
      end
      if (wr_fire && sel == `PIFR_SEL_TX && chan == i) begin
        next_tx_full[i] = 1'b1;
        next_tx_data[i*UW +: UW] = avs_writedata[UW-1:0];
      end
    end
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_full      <= {NU{`PIFR_RST_FLAG}};
      rx_buf       <= {NU{`PIFR_RST_BYTE}};
      tx_empty     <= {NU{`PIFR_RST_FLAG}};
      uart_tx_full <= {NU{`PIFR_RST_FLAG}};
      uart_tx_data <= {NU{`PIFR_RST_BYTE}};
    end else begin
      rx_full      <= next_rx_full;
      rx_buf       <= next_rx_buf;
      // an empty buffer shows from the first edge after reset
      tx_empty     <= ~next_tx_full;
      uart_tx_full <= next_tx_full;
      uart_tx_data <= next_tx_data;
    end
  end

  // read-only view, no write path reaches it
  assign serial_channel_flags = {2'h0,
                                 rx_full[2], tx_empty[2],
                                 rx_full[1], tx_empty[1],
                                 rx_full[0], tx_empty[0]};

  // timer period match, taken on the first cycle of equality
  wire [`PIFR_NUM_TMR-1:0] tmr_eq;
  reg  [`PIFR_NUM_TMR-1:0] tmr_eq_d;
  wire [`PIFR_NUM_TMR-1:0] tmr_set;

  genvar g;
  generate
    for (g = 0; g < `PIFR_NUM_TMR; g = g + 1) begin : g_tmr
      assign tmr_eq[g] = tmr_count[g*TMR_W +: TMR_W] ==
                         tmr_period[g*TMR_W +: TMR_W];
    end
  endgenerate

  // a timer parked on its period would otherwise block a clear
  assign tmr_set = tmr_eq & ~tmr_eq_d;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tmr_eq_d <= {`PIFR_NUM_TMR{`PIFR_RST_FLAG}};
    end else begin
      tmr_eq_d <= tmr_eq;
    end
  end

  pifr_flag_bank #(
    .W (`PIFR_NUM_TMR)
  ) u_tmr (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .set     (tmr_set),
    .wr_en   (wr_fire & (sel == `PIFR_SEL_TMR_MATCH)),
    .wr_data (avs_writedata[`PIFR_NUM_TMR-1:0]),
    .flags   (timer_match_flags)
  );

  // timer gate events, bits 3..0 for timers seven, five, three, one
  wire [`PIFR_NUM_GATE-1:0] gate_q;

  pifr_flag_bank #(
    .W (`PIFR_NUM_GATE)
  ) u_gate (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .set     (tmr_gate_event),
    .wr_en   (wr_fire & (sel == `PIFR_SEL_TMR_GATE)),
    .wr_data (avs_writedata[`PIFR_NUM_GATE-1:0]),
    .flags   (gate_q)
  );

  assign timer_gate_flags = {4'h0, gate_q};

  // capture/compare events gated by each module's mode
  reg  [`PIFR_NUM_CCP-1:0] ccp_set;
  wire [`PIFR_NUM_CCP-1:0] ccp_q;
  reg  [1:0]               mode;
  integer                  k;

  always @* begin
    ccp_set = {`PIFR_NUM_CCP{1'b0}};
    mode    = `PIFR_CCP_OFF;
    for (k = 0; k < `PIFR_NUM_CCP; k = k + 1) begin
      mode = ccp_mode[k*`PIFR_CCP_MODE_W +: `PIFR_CCP_MODE_W];
      case (mode)
        `PIFR_CCP_CAPTURE: ccp_set[k] = ccp_capture[k];
        `PIFR_CCP_COMPARE: ccp_set[k] = ccp_match[k];
        default:           ccp_set[k] = 1'b0;
      endcase
    end
  end

  pifr_flag_bank #(
    .W (`PIFR_NUM_CCP)
  ) u_ccp (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .set     (ccp_set),
    .wr_en   (wr_fire & (sel == `PIFR_SEL_CAPCOMP)),
    .wr_data (avs_writedata[`PIFR_NUM_CCP-1:0]),
    .flags   (ccp_q)
  );

  assign capture_compare_flags = {3'h0, ccp_q};

  // read data, captured in the wait cycle and held through the answer
  reg [7:0] rd_byte;

  always @* begin
    rd_byte = `PIFR_RST_BYTE;
    case (sel)
      `PIFR_SEL_SER_CHAN:  rd_byte = serial_channel_flags;
      `PIFR_SEL_TMR_MATCH: rd_byte = timer_match_flags;
      `PIFR_SEL_TMR_GATE:  rd_byte = timer_gate_flags;
      `PIFR_SEL_CAPCOMP:   rd_byte = capture_compare_flags;
      `PIFR_SEL_SSP_DONE:  rd_byte = serial_port_flags;
      `PIFR_SEL_RX:        rd_byte = rx_buf[chan*UW +: UW];
      `PIFR_SEL_TX:        rd_byte = uart_tx_data[chan*UW +: UW];
      default:             rd_byte = `PIFR_RST_BYTE;
    endcase
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= `PIFR_RST_WORD;
    end else if (avs_read && !ack) begin
      avs_readdata <= {24'h000000, rd_byte};
    end
  end

endmodule // pifr_flag_regs

`default_nettype wire

// ---- pifr_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module pifr_chk (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        nrst,
  // bus and event inputs
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  ssp_done,
  input wire logic [2:0]  uart_rx_load,
  input wire logic [2:0]  uart_tx_full,
  input wire logic [63:0] tmr_count,
  input wire logic [63:0] tmr_period,
  input wire logic [3:0]  tmr_gate_event,
  input wire logic [9:0]  ccp_mode,
  input wire logic [4:0]  ccp_capture,
  // flag outputs
  input wire logic [7:0]  serial_port_flags,
  input wire logic [7:0]  serial_channel_flags,
  input wire logic [7:0]  timer_match_flags,
  input wire logic [7:0]  timer_gate_flags,
  input wire logic [7:0]  capture_compare_flags
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_ssp_sets: assert property (
    ssp_done[1] |=> serial_port_flags[2])
    else $error("port two done flag not set");
  a_ssp_holds: assert property (
    serial_port_flags[0] && !avs_write |=> serial_port_flags[0])
    else $error("done flag dropped alone");
  a_rx_sets: assert property (
    uart_rx_load[2] |=> serial_channel_flags[5])
    else $error("rx flag not set on load");
  a_tx_follows: assert property (
    $past(nrst) |-> {serial_channel_flags[4], serial_channel_flags[2],
    serial_channel_flags[0]} == ~uart_tx_full)
    else $error("tx flag does not match buffer state");
  a_unused_zero: assert property (
    serial_channel_flags[7:6] == 2'h0 && timer_gate_flags[7:4] == 4'h0 &&
    capture_compare_flags[7:5] == 3'h0)
    else $error("unimplemented bit reads one");
  a_match_sets: assert property (
    $rose(tmr_count[63:56] == tmr_period[63:56]) |=> timer_match_flags[7])
    else $error("timer eight match flag not set");
  a_gate_sets: assert property (
    tmr_gate_event[0] |=> timer_gate_flags[0])
    else $error("gate flag not set");
  a_capture_sets: assert property (
    ccp_mode[1:0] == 2'h1 && ccp_capture[0] |=> capture_compare_flags[0])
    else $error("capture flag not set");
  a_pwm_quiet: assert property (
    ccp_mode[9:8] == 2'h3 && !avs_write && !capture_compare_flags[4]
    |=> !capture_compare_flags[4])
    else $error("flag set in pwm mode");
  a_one_wait: assert property ($rose(avs_read || avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("wait state count");
endmodule // pifr_chk
bind pifr_flag_regs pifr_chk u_chk (.ref_clk, .nrst, .avs_read, .avs_write,
  .avs_waitrequest, .ssp_done, .uart_rx_load, .uart_tx_full, .tmr_count,
  .tmr_period, .tmr_gate_event, .ccp_mode, .ccp_capture, .serial_port_flags,
  .serial_channel_flags, .timer_match_flags, .timer_gate_flags,
  .capture_compare_flags);
`default_nettype wire

// ---- pifr_periph.sv ----
`timescale 1ns/1ns
`default_nettype none
// shifters that take each tx byte after a delay and loop it back as rx
module pifr_periph (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // slow shifter when high
  input  wire logic        slow,
  // tx side
  input  wire logic [2:0]  tx_full,
  input  wire logic [23:0] tx_data,
  output var  logic [2:0]  tx_take,
  // rx side
  output var  logic [2:0]  rx_load,
  output wire logic [23:0] rx_data
);
  logic [3:0]  cnt [3];
  logic [23:0] held;
  // inverse outside a load so a stale byte is never taken by luck
  assign rx_data = held ^ {{8{!rx_load[2]}}, {8{!rx_load[1]}},
                           {8{!rx_load[0]}}};
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_take <= 3'h0;
      rx_load <= 3'h0;
      held    <= 24'h0;
      for (int i = 0; i < 3; i++)
        cnt[i] <= 4'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        tx_take[i] <= 1'h0;
        rx_load[i] <= tx_take[i];
        if (tx_full[i] && !tx_take[i]) begin
          cnt[i] <= cnt[i] + 4'h1;
          if (cnt[i] == (slow ? 4'h6 : 4'h1)) begin
            tx_take[i]   <= 1'h1;
            held[i*8+:8] <= tx_data[i*8+:8];
            cnt[i]       <= 4'h0;
          end
        end
      end
    end
  end
endmodule // pifr_periph
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "pifr_regs.vh"
module tb_top;
  logic        ref_clk, nrst, avs_read, avs_write, slow;
  logic [13:0] avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  ssp_done;
  logic [2:0]  uart_rx_load, uart_tx_take, uart_tx_full;
  logic [23:0] uart_rx_data, uart_tx_data;
  logic [63:0] tmr_count, tmr_period;
  logic [3:0]  tmr_gate_event;
  logic [9:0]  ccp_mode;
  logic [4:0]  ccp_capture, ccp_match;
  logic [7:0]  sp_f, sc_f, tm_f, tg_f, cc_f;
  int          n_mismatch, samples_checked, i;
  localparam logic [23:0] rw_masks = 24'h1F0FFF;

  pifr_flag_regs DUT (.ref_clk, .nrst, .avs_address, .avs_read,
    .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .ssp_done, .uart_rx_load, .uart_rx_data,
    .uart_tx_take, .uart_tx_data, .uart_tx_full, .tmr_count,
    .tmr_period, .tmr_gate_event, .ccp_mode, .ccp_capture, .ccp_match,
    .serial_port_flags(sp_f), .serial_channel_flags(sc_f),
    .timer_match_flags(tm_f), .timer_gate_flags(tg_f),
    .capture_compare_flags(cc_f));
  pifr_periph u_per (.ref_clk, .nrst, .slow, .tx_full(uart_tx_full),
    .tx_data(uart_tx_data), .tx_take(uart_tx_take),
    .rx_load(uart_rx_load), .rx_data(uart_rx_data));

  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // a spare edge first, so a release and a new request never share a step
  task automatic bus(input logic w, input logic [11:0] idx,
                     input logic [7:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    avs_address   <= {idx, 2'h0};
    avs_writedata <= {24'h0, d};
    avs_write     <= w;
    avs_read      <= !w;
    @(posedge ref_clk);
    while (avs_waitrequest)
      @(posedge ref_clk);
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read  <= 1'h0;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'h1, idx, d, q);
  endtask

  task automatic rd_chk(input logic [11:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'h0, idx, 8'h00, q);
    chk(q[7:0], exp);
  endtask

  task automatic tally_and_finish;
    $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #20000;
    n_mismatch++;
    tally_and_finish;
  end

  initial begin
    nrst = 1'h0;
    slow = 1'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_address = 14'h0000;
    avs_byteenable = 4'hF;
    avs_writedata = 32'h0000_0000;
    ssp_done = 2'h0;
    tmr_count = 64'h0;
    tmr_period = {8{8'h05}};
    tmr_gate_event = 4'h0;
    ccp_mode = 10'h000;
    ccp_capture = 5'h00;
    ccp_match = 5'h00;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'h1;
    rd_chk(`PIFR_IDX_SER_CHAN, 8'h15);
    wr(`PIFR_IDX_SER_CHAN, 8'h00);
    rd_chk(`PIFR_IDX_SER_CHAN, 8'h15);
    wr(12'hE50, 8'hFF);
    rd_chk(12'hE50, 8'h00);
    for (i = 0; i < 3; i++) begin
      rd_chk(12'hE38 + i[1:0], 8'h00);
      wr(12'hE38 + i[1:0], 8'hFF);
      rd_chk(12'hE38 + i[1:0], rw_masks[i*8+:8]);
      wr(12'hE38 + i[1:0], 8'h00);
    end
    $display("register access test done");
    // capture on modules one three five, compare on two and four
    ccp_mode       <= 10'h199;
    tmr_count      <= {8{8'h05}};
    ssp_done       <= 2'h3;
    tmr_gate_event <= 4'hF;
    ccp_capture    <= 5'h15;
    ccp_match      <= 5'h0A;
    @(posedge ref_clk);
    ssp_done       <= 2'h0;
    tmr_gate_event <= 4'h0;
    ccp_capture    <= 5'h00;
    ccp_match      <= 5'h00;
    @(posedge ref_clk);
    chk(sp_f, 8'h05);
    chk(tm_f, 8'hFF);
    chk(tg_f, 8'h0F);
    chk(cc_f, 8'h1F);
    wr(`PIFR_IDX_SSP_DONE, 8'h00);
    wr(`PIFR_IDX_TMR_MATCH, 8'h00);
    wr(`PIFR_IDX_CAPCOMP, 8'h00);
    rd_chk(`PIFR_IDX_SSP_DONE, 8'h00);
    rd_chk(`PIFR_IDX_TMR_MATCH, 8'h00);
    ccp_mode    <= 10'h333;
    ccp_capture <= 5'h1F;
    ccp_match   <= 5'h1F;
    @(posedge ref_clk);
    ccp_capture <= 5'h00;
    ccp_match   <= 5'h00;
    rd_chk(`PIFR_IDX_CAPCOMP, 8'h00);
    fork
      wr(`PIFR_IDX_TMR_GATE, 8'h00);
      begin
        repeat (2) @(posedge ref_clk);
        tmr_gate_event <= 4'h1;
        @(posedge ref_clk);
        tmr_gate_event <= 4'h0;
      end
    join
    // a write without its low byte lane must leave the flags alone
    avs_byteenable <= 4'hE;
    wr(`PIFR_IDX_TMR_GATE, 8'h0E);
    avs_byteenable <= 4'hF;
    rd_chk(`PIFR_IDX_TMR_GATE, 8'h01);
    $display("event flag test done");
    for (i = 0; i < 2; i++) begin
      slow <= i[0];
      wr(`PIFR_IDX_TX5, 8'h3C + i[7:0]);
      @(posedge ref_clk);
      chk(sc_f, 8'h05);
      chk(uart_tx_data[23:16], 8'h3C + i[7:0]);
      for (int k = 0; k < 30 && !sc_f[5]; k++)
        @(posedge ref_clk);
      chk(sc_f, 8'h35);
      rd_chk(`PIFR_IDX_RX5, 8'h3C + i[7:0]);
      @(posedge ref_clk);
      chk(sc_f, 8'h15);
    end
    $display("serial channel test done");
    tally_and_finish;
  end
endmodule // tb_top
`default_nettype wire
